// file: hw/usr_defines.svh
`ifndef USR_DEFINES_SVH
`define USR_DEFINES_SVH

// Register geometry
`define USR_STAGES 4
`define USR_LAST_STAGE 3

// Command word layout as held in the FIFO
`define USR_CMD_W 7
`define USR_CMD_PAR_LSB 0
`define USR_CMD_PAR_MSB 3
`define USR_CMD_K_N 4
`define USR_CMD_J 5
`define USR_CMD_LOAD_N 6

// FIFO geometry
`define USR_FIFO_DEPTH 16

// Reset values
`define USR_STAGE_RST 4'h0
`define USR_INV_RST 1'h1
`define USR_READY_RST 1'h1

`endif

// file: hw/usr_pkg.sv
package usr_pkg;

  // First-stage action, encoded as {j, k_n}
  typedef enum logic [1:0] {
    USR_JK_CLEAR  = 2'h0,
    USR_JK_HOLD   = 2'h1,
    USR_JK_TOGGLE = 2'h2,
    USR_JK_SET    = 2'h3
  } usr_jk_e;

  // Operating mode, encoded as parallel_load_n
  typedef enum logic {
    USR_MODE_LOAD  = 1'h0,
    USR_MODE_SHIFT = 1'h1
  } usr_mode_e;

endpackage

// file: hw/usr_fifo.sv
`timescale 1ns/100ps
`include "usr_defines.svh"

module usr_fifo
  import usr_pkg::*;
#(
  parameter int WIDTH = `USR_CMD_W,
  parameter int DEPTH = `USR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  // Flags are registered so ready and valid come from flip-flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= '0;
      o_in_ready <= `USR_READY_RST;
      o_out_valid <= 1'h0;
    end else begin
      count <= next_count;
      o_in_ready <= (next_count != FULL_CNT);
      o_out_valid <= (next_count != '0);
    end
  end

endmodule

// file: hw/usr_shift_register.sv
`timescale 1ns/100ps
`include "usr_defines.svh"
// Overview of operation
// - Outside master clear, state changes only on the rising clock edge.
// - Load mode: all four stages take the parallel inputs in one clock.
// - Shift mode: stage n takes old stage n-1 for n from 1 to 3.
// - Shift mode stage 0 from j,k_n: clear, hold, toggle, set.
// - Low master clear at once zeroes stages and sets inverted output.
// - While master clear is low the reset state holds against all inputs.
// - Each stage has its output, plus the inverse of the last stage.

module usr_shift_register
  import usr_pkg::*;
#(
  parameter int STAGES = `USR_STAGES,
  parameter int FIFO_DEPTH = `USR_FIFO_DEPTH
) (
  // Clock and master clear
  input wire logic i_clk,
  input wire logic i_nrst,
  // Command stream from the driving logic
  input wire logic i_cmd_valid,
  input wire logic i_parallel_load_n,
  input wire logic i_j,
  input wire logic i_k_n,
  input wire logic [STAGES-1:0] i_parallel_inputs,
  output logic o_cmd_ready,
  // Drain control, low stalls the register
  input wire logic i_step_en,
  // Register state
  output logic [STAGES-1:0] o_stage_outputs,
  output logic o_last_stage_out_inv
);

  logic [`USR_CMD_W-1:0] cmd_in;
  logic [`USR_CMD_W-1:0] cmd;
  logic cmd_valid;
  logic fifo_in_ready;
  logic step;
  usr_mode_e mode;
  usr_jk_e jk;
  logic [STAGES-1:0] par;
  logic [STAGES-1:0] next_stage;
  logic next_first;

  assign cmd_in = {i_parallel_load_n, i_j, i_k_n, i_parallel_inputs};
  assign o_cmd_ready = fifo_in_ready;

  usr_fifo #(
    .WIDTH(`USR_CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_in_valid(i_cmd_valid),
    .i_in_data(cmd_in),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(cmd_valid),
    .o_out_data(cmd),
    .i_out_ready(i_step_en)
  );

  // One queued command is applied per enabled edge
  assign step = cmd_valid & i_step_en;
  assign mode = usr_mode_e'(cmd[`USR_CMD_LOAD_N]);
  assign jk = usr_jk_e'({cmd[`USR_CMD_J], cmd[`USR_CMD_K_N]});
  assign par = cmd[`USR_CMD_PAR_MSB:`USR_CMD_PAR_LSB];

  // First stage: J/K action in shift mode
  always_comb begin
    if (mode == USR_MODE_LOAD) begin
      next_first = par[0];
    end else begin
      case (jk)
        USR_JK_CLEAR: next_first = 1'h0;
        USR_JK_HOLD: next_first = o_stage_outputs[0];
        USR_JK_TOGGLE: next_first = ~o_stage_outputs[0];
        USR_JK_SET: next_first = 1'h1;
        default: next_first = o_stage_outputs[0];
      endcase
    end
  end

  // Kept apart so the vector has only continuous drivers
  assign next_stage[0] = next_first;

  // Later stages: load or shift right
  genvar g;
  generate
    for (g = 1; g < STAGES; g = g + 1) begin : g_stage
      assign next_stage[g] = (mode == USR_MODE_LOAD) ? par[g]
                                                     : o_stage_outputs[g-1];
    end
  endgenerate

  // Master clear is asynchronous and dominant
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_stage_outputs <= `USR_STAGE_RST;
      o_last_stage_out_inv <= `USR_INV_RST;
    end else if (step) begin
      o_stage_outputs <= next_stage;
      o_last_stage_out_inv <= ~next_stage[STAGES-1];
    end
  end

endmodule

// file: dv/usr_properties.sv
`timescale 1ns/100ps
module usr_properties #(parameter int STAGES = 4) (
  input wire logic i_clk, i_nrst, i_cmd_valid, o_cmd_ready, i_step_en,
  input wire logic i_parallel_load_n, i_j, i_k_n, o_last_stage_out_inv,
  input wire logic [STAGES-1:0] i_parallel_inputs, o_stage_outputs
);
  logic [4:0] cnt;
  wire tk = i_cmd_valid && o_cmd_ready;
  wire [STAGES-1:0] q = o_stage_outputs;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst) cnt <= 5'h0;
    else cnt <= cnt + 5'(tk) - 5'(i_step_en && cnt != 5'h0);
  // Lone command taken into an empty queue, popped at the next edge
  sequence s_lone(m);
    tk && cnt == 5'h0 && i_parallel_load_n == m ##1 i_step_en;
  endsequence
  chk_inv_tracks: assert property (
    o_last_stage_out_inv == !q[STAGES-1]) else $error("inv");
  chk_clear_now: assert property (disable iff (1'b0)
    !i_nrst |-> q == '0 && o_last_stage_out_inv) else $error("clr");
  chk_clear_holds: assert property (disable iff (1'b0)
    !i_nrst [*2] |-> q == '0 && o_cmd_ready) else $error("hold");
  chk_release_hold: assert property (
    $rose(i_nrst) |-> q == '0 ##1 q == '0) else $error("rel");
  chk_stall_stable: assert property (
    !i_step_en |=> $stable(q)) else $error("stall");
  chk_load_apply: assert property (
    s_lone(1'b0) |=> q == $past(i_parallel_inputs, 2)) else $error("load");
  chk_shift_move: assert property (
    s_lone(1'b1) |=> q[STAGES-1:1] == $past(q[STAGES-2:0]))
    else $error("shift");
  chk_first_stage: assert property (
    s_lone(1'b1) |=> q[0] == ($past(i_j, 2) && !$past(q[0]) ||
    $past(i_k_n, 2) && $past(q[0]))) else $error("jk");
endmodule

// file: dv/usr_driver.sv
`timescale 1ns/100ps
module usr_driver (
  input wire logic i_clk, i_ready,
  output logic o_valid, o_load_n, o_j, o_k_n,
  output logic [3:0] o_p
);
  initial {o_valid, o_load_n, o_j, o_k_n, o_p} = 8'h00;
  // Hold the word until taken, then idle for gap cycles
  task automatic send(input logic [6:0] w, input int gap);
    {o_load_n, o_j, o_k_n, o_p} = w;
    o_valid = 1'b1;
    while (!i_ready) @(posedge i_clk) #1;
    @(posedge i_clk) #1;
    if (gap > 0) o_valid = 1'b0;
    repeat (gap) @(posedge i_clk) #1;
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 0, nrst = 1, step = 1, v, ld, j, kn, rdy, inv;
  logic [3:0] p, o, m = 0;
  logic [6:0] w, q[$];
  int errors = 0, n_tests = 0, cyc = 0, seed = 32'h4a6746e4;
  always #10 clk = ~clk;
  usr_driver drv (.i_clk(clk), .i_ready(rdy), .o_valid(v), .o_load_n(ld),
    .o_j(j), .o_k_n(kn), .o_p(p));
  usr_shift_register uut (.i_clk(clk), .i_nrst(nrst), .i_cmd_valid(v),
    .i_parallel_load_n(ld), .i_j(j), .i_k_n(kn), .i_parallel_inputs(p),
    .o_cmd_ready(rdy), .i_step_en(step), .o_stage_outputs(o),
    .o_last_stage_out_inv(inv));
  task chk(input logic [5:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Model checks, then advances to the coming edge
  always @(negedge clk) begin
    if (!nrst) begin
      m = 0;
      q.delete();
    end
    chk({rdy, inv, o}, {q.size() < 16, !m[3], m});
    if (nrst && step && q.size() > 0) begin
      w = q.pop_front();
      m = w[6] ? {m[2:0], w[5] & !m[0] | w[4] & m[0]} : w[3:0];
    end
    if (nrst && v && rdy) q.push_back({ld, j, kn, p});
    cyc++;
    if (cyc > 3000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    #1 nrst = 0;
    repeat (10) @(posedge clk);
    #1 nrst = 1;
    for (int i = 0; i < 8; i++) drv.send({i[2], i[1:0], 4'hA}, 4);
    repeat (300) begin
      step = $random(seed) | !rdy;
      drv.send(7'($random(seed)), $random(seed) & 3);
    end
    step = 1;
    drv.send(7'h00, 20);
    step = 0;
    repeat (16) drv.send(7'($random(seed)), 0);
    #60 step = 1;
    #100 drv.o_valid = 0;
    #400 drv.send(7'h0F, 0);
    #45 nrst = 0;
    #1 chk({rdy, inv, o}, 6'h30);
    #54 nrst = 1;
    #200 report_and_stop;
  end
endmodule
bind usr_shift_register usr_properties #(.STAGES(STAGES)) u_chk (.*);
